// File: verilog/srm_regs.svh
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

// register byte offsets
`define SRM_ADDR_CTRL 8'h00
`define SRM_ADDR_TIM 8'h04
`define SRM_ADDR_EXT 8'h08
`define SRM_ADDR_MEMORY_TYPE_FIELD 8'h0C
`define SRM_ADDR_STAT 8'h10

// control register fields
`define SRM_CTRL_REFRESH_ENABLE_BIT 0
`define SRM_CTRL_SELF 1
`define SRM_CTRL_MODE_GO 2
`define SRM_CTRL_NARROW 3
`define SRM_CTRL_WIDTH_LSB 4
`define SRM_CTRL_CSZ_LSB 6

// timing and extension fields
`define SRM_TIM_EXTRA_REFRESH_COUNT_LSB 12
`define SRM_EXT_TCL 0
`define SRM_EXT_MIN_ACTIVE_TIME_LSB 4

// reset values
`define SRM_CTRL_RESET 8'h00
`define SRM_TIM_RESET 15'h05DC
`define SRM_EXT_RESET 9'h071
`define SRM_MEMORY_TYPE_FIELD_RESET 4'h0

// timing counts and fixed values
`define SRM_WAKE_CYCLES 8'h10
`define SRM_MAX_EXTRA 3'h4
`define SRM_MODE_BASE 14'h0022
`define SRM_PRE_BIT 10
`define SRM_COL_BASE 4'h8

`endif

// File: verilog/srm_pkg.sv
package srm_pkg;

	// controller states, gray along the usual access path
	typedef enum logic [3:0] {
		SRM_IDLE = 4'h0,
		SRM_ACT = 4'h1,
		SRM_COL = 4'h3,
		SRM_CLOSE = 4'h2,
		SRM_RF_PRE = 4'h6,
		SRM_RF_REF = 4'h7,
		SRM_MODE = 4'h5,
		SRM_SR_PRE = 4'h4,
		SRM_SR_REF = 4'hC,
		SRM_SR_IN = 4'hD,
		SRM_SR_WAKE = 4'hF,
		SRM_HOLD = 4'hE
	} srm_state_type;

	// sdram op codes as {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		SRM_OP_MRS = 3'h0,
		SRM_OP_REF = 3'h1,
		SRM_OP_PRE = 3'h2,
		SRM_OP_ACT = 3'h3,
		SRM_OP_WRITE = 3'h4,
		SRM_OP_READ = 3'h5,
		SRM_OP_NOP = 3'h7
	} srm_op_type;

	// command bundle on the sdram pins
	typedef struct packed {
		logic [3:0] cs_n;
		srm_op_type op;
	} srm_cmd_type;

	// access request from the system side
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] ce;
		logic we;
		logic peripheral_direct_transfer;
	} srm_access_type;

endpackage

// File: verilog/srm_ctrl.sv
`timescale 1ns/100ps
`include "srm_regs.svh"

module srm_ctrl import srm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// access requests, same clock domain
	input wire logic acc_req_i,
	input wire srm_access_type acc_i,
	output logic acc_done_o,
	// pins from outside
	input wire logic memory_clock_out_i,
	input wire logic hold_req_i,
	output logic hold_acknowledge_o,
	// sdram pins
	output srm_cmd_type sdram_cmd_o,
	output logic [20:0] external_address_bus_o,
	output logic sdram_clock_enable_out_o
);

	// register storage
	logic [7:0] ctrl_q; // control fields except self-refresh and mode go
	logic [14:0] tim_q; // refresh period and extra count
	logic [8:0] ext_q; // latency select and min active time
	logic [3:0] memory_type_field_q; // one sdram flag per chip-enable space
	logic mode_go_q; // pending mode-set command
	logic ack_q; // wishbone acknowledge
	logic [31:0] rdata_q; // registered read data

	// self-refresh bookkeeping
	logic sr_q; // self_refresh_request_bit as seen on the pin
	logic sr_pend_q; // entry requested, banks not yet closed
	logic exit_req_q; // exit requested by software

	// synchronisers and edge detection
	logic mclk_s1_q, mclk_s2_q, mclk_prev_q;
	logic hold_s1_q, hold_s2_q;

	// controller state and pin registers
	srm_state_type state_q, state_d;
	srm_cmd_type cmd_q, cmd_d;
	logic [16:0] la_q, la_d; // logical address lines before pin mapping
	logic [4:0] upper_q; // row bits above the precharge line
	logic flag_q; // access flag latched at activate
	logic [7:0] wait_q, wait_d; // self-refresh and wake counter
	logic [11:0] rcnt_q; // refresh period counter
	logic [3:0] rpend_q; // refreshes owed
	logic done_q, done_d;

	// field views
	wire logic refresh_enable_bit = ctrl_q[`SRM_CTRL_REFRESH_ENABLE_BIT];
	wire logic narrow = ctrl_q[`SRM_CTRL_NARROW];
	wire logic [1:0] width_code = ctrl_q[`SRM_CTRL_WIDTH_LSB +: 2];
	wire logic [1:0] csz = ctrl_q[`SRM_CTRL_CSZ_LSB +: 2];
	wire logic [11:0] period = tim_q[11:0];
	wire logic [2:0] extra_refresh_count = tim_q[`SRM_TIM_EXTRA_REFRESH_COUNT_LSB +: 3];
	wire logic cas_latency_select = ext_q[`SRM_EXT_TCL];
	// min active time keeps five stored bits; the upper count bits read as zero
	wire logic [7:0] min_active_time = {3'b000, ext_q[`SRM_EXT_MIN_ACTIVE_TIME_LSB +: 5]};
	wire logic sdram_present = |memory_type_field_q;

	// memory clock tick and synchronised hold request
	wire logic mtick = mclk_s2_q & ~mclk_prev_q;
	wire logic hold_req = hold_s2_q;
	wire logic in_hold = (state_q == SRM_HOLD);

	// wishbone decode
	// a request already acknowledged is not taken a second time
	wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	wire logic [7:0] wb_off = {wb_adr_i[7:2], 2'b00};
	wire logic hit_ctrl = (wb_off == `SRM_ADDR_CTRL);
	wire logic hit_tim = (wb_off == `SRM_ADDR_TIM);
	wire logic hit_ext = (wb_off == `SRM_ADDR_EXT);
	wire logic hit_memory_type_field = (wb_off == `SRM_ADDR_MEMORY_TYPE_FIELD);
	wire logic hit_stat = (wb_off == `SRM_ADDR_STAT);
	wire logic wr_ctrl = wb_wr & hit_ctrl;
	wire logic wr_self = wr_ctrl & ~in_hold;
	wire logic self_val = wb_dat_i[`SRM_CTRL_SELF];
	wire logic self_seen = sr_q | sr_pend_q;

	// read data mux, unmapped offsets read zero
	wire logic [31:0] ctrl_rd = {24'h00_0000, ctrl_q[7:3], mode_go_q, self_seen, refresh_enable_bit};
	wire logic [31:0] stat_rd = {16'h0000, 4'h0, rpend_q, state_q, 1'b0, exit_req_q,
		hold_acknowledge_o, sr_q};
	wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd :
		hit_tim ? {17'h0_0000, tim_q} :
		hit_ext ? {23'h00_0000, ext_q} :
		hit_memory_type_field ? {28'h000_0000, memory_type_field_q} :
		hit_stat ? stat_rd : 32'h0000_0000;

	// address split: byte offset bits, column mask, row shift
	// bank and row size never enter the shift, only column size and width
	wire logic [1:0] boff = narrow ? {1'b0, width_code[0]} : width_code;
	wire logic [1:0] ncb_add = (csz == 2'h3) ? 2'h2 : csz;
	wire logic [3:0] col_bits = `SRM_COL_BASE + {2'b00, ncb_add};
	wire logic [3:0] row_shift = col_bits + {2'b00, boff};
	wire logic [31:0] row_addr = acc_i.addr >> row_shift;
	wire logic [31:0] col_addr = acc_i.addr >> boff;
	wire logic [9:0] col_mask = (ncb_add == 2'h0) ? 10'h0FF :
		(ncb_add == 2'h1) ? 10'h1FF : 10'h3FF;
	wire logic [9:0] col_val = col_addr[9:0] & col_mask;
	wire logic flag = ~acc_i.peripheral_direct_transfer;
	wire logic [3:0] sd_cs_n = ~memory_type_field_q;
	wire logic [3:0] acc_cs_n = ~(4'h1 << acc_i.ce);

	// mode value: burst four sequential, latency 01x, rest zero
	// mode bit ten lands on the precharge line and stays zero
	wire logic [13:0] mode_val = `SRM_MODE_BASE | {9'h000, cas_latency_select, 4'h0};

	// refresh extras saturate at the maximum
	wire logic [2:0] extra = (extra_refresh_count > `SRM_MAX_EXTRA) ? `SRM_MAX_EXTRA : extra_refresh_count;
	wire logic rf_expire = mtick & refresh_enable_bit & (rcnt_q == 12'h000);
	wire logic rf_take = mtick & (state_q == SRM_RF_REF);

	// wishbone registers: ack one cycle after the request, dropped next
	// read data is caught with the request so it stands during the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req;
			if (wb_req) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `SRM_CTRL_RESET;
			tim_q <= `SRM_TIM_RESET;
			ext_q <= `SRM_EXT_RESET;
			memory_type_field_q <= `SRM_MEMORY_TYPE_FIELD_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {wb_dat_i[7:3], 3'b000} | {7'h00, wb_dat_i[`SRM_CTRL_REFRESH_ENABLE_BIT]};
			end
			if (wb_wr & hit_tim) begin
				tim_q <= {wb_sel_i[1] ? wb_dat_i[14:8] : tim_q[14:8], wb_dat_i[7:0]};
			end
			if (wb_wr & hit_ext) begin
				ext_q <= {wb_sel_i[1] ? wb_dat_i[8] : ext_q[8], wb_dat_i[7:0]};
			end
			if (wb_wr & hit_memory_type_field) begin
				memory_type_field_q <= wb_dat_i[3:0];
			end
		end
	end

	// mode-set go bit: a write of one arms it, issue clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_go_q <= 1'b0;
		end else if (wr_ctrl & wb_dat_i[`SRM_CTRL_MODE_GO]) begin
			mode_go_q <= 1'b1;
		end else if (mtick & (state_q == SRM_MODE)) begin
			mode_go_q <= 1'b0;
		end
	end

	// self-refresh bit, entry and exit requests
	// entry and exit land on a memory clock tick, so cke moves with a command
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_q <= 1'b0;
			sr_pend_q <= 1'b0;
			exit_req_q <= 1'b0;
		end else begin
			if (mtick & (state_q == SRM_SR_PRE)) begin
				sr_q <= 1'b1; // cke falls with the refresh command
				sr_pend_q <= 1'b0;
			end else if (mtick & (state_q == SRM_SR_IN) & (state_d == SRM_SR_WAKE)) begin
				sr_q <= 1'b0;
				exit_req_q <= 1'b0;
			end else if (wr_self & ~sdram_present) begin
				sr_q <= self_val; // plain output when no sdram is fitted
			end else if (wr_self & self_val & ~sr_q) begin
				sr_pend_q <= 1'b1;
			end else if (wr_self & ~self_val) begin
				sr_pend_q <= 1'b0;
				exit_req_q <= sr_q;
			end
		end
	end

	// two-flop synchronisers for the memory clock and hold pins
	// the first flop feeds no logic and may go metastable; the edge detect also uses the flop after the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mclk_s1_q <= 1'b0;
			mclk_s2_q <= 1'b0;
			mclk_prev_q <= 1'b0;
			hold_s1_q <= 1'b0;
			hold_s2_q <= 1'b0;
		end else begin
			mclk_s1_q <= memory_clock_out_i;
			mclk_s2_q <= mclk_s1_q;
			mclk_prev_q <= mclk_s2_q;
			hold_s1_q <= hold_req_i;
			hold_s2_q <= hold_s1_q;
		end
	end

	// refresh period counter and refreshes owed
	// expiry owes one refresh plus the clamped extras; a refresh taken in
	// the same tick is netted out so none is lost or counted twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcnt_q <= 12'h000;
			rpend_q <= 4'h0;
		end else if (~refresh_enable_bit) begin
			rcnt_q <= period;
			rpend_q <= 4'h0;
		end else begin
			if (rf_expire) begin
				rcnt_q <= period;
			end else if (mtick) begin
				rcnt_q <= rcnt_q - 12'h001;
			end
			if (rf_expire) begin
				rpend_q <= rpend_q - {3'b000, rf_take} + 4'h1 + {1'b0, extra};
			end else if (rf_take) begin
				rpend_q <= rpend_q - 4'h1;
			end
		end
	end

	// next state and next command
	// idle priority: hold, refresh owed, self-refresh entry, mode set, access
	always_comb begin
		state_d = state_q;
		cmd_d = '{cs_n: 4'hF, op: SRM_OP_NOP};
		la_d = 17'h0_0000;
		wait_d = wait_q;
		done_d = 1'b0;
		case (state_q)
			SRM_IDLE: begin
				if (hold_req) begin
					state_d = SRM_HOLD;
				end else if (refresh_enable_bit & (rpend_q != 4'h0)) begin
					// close all banks first
					state_d = SRM_RF_PRE;
					cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_PRE};
					la_d[`SRM_PRE_BIT] = 1'b1;
				end else if (sr_pend_q) begin
					// close every open page before entry
					state_d = SRM_SR_PRE;
					cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_PRE};
					la_d[`SRM_PRE_BIT] = 1'b1;
				end else if (mode_go_q) begin
					state_d = SRM_MODE;
					cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_MRS};
					la_d = {3'b000, mode_val};
				end else if (acc_req_i & ~sr_q) begin
					state_d = SRM_ACT;
					cmd_d = '{cs_n: acc_cs_n, op: SRM_OP_ACT};
					la_d = {flag, row_addr[15:0]};
				end
			end
			SRM_ACT: begin
				// column phase: latched upper bits, precharge line low
				state_d = SRM_COL;
				cmd_d = '{cs_n: acc_cs_n, op: acc_i.we ? SRM_OP_WRITE : SRM_OP_READ};
				la_d = {flag_q, upper_q, 1'b0, col_val};
				done_d = 1'b1;
			end
			SRM_COL: begin
				// close the bank so each access is self-contained
				state_d = SRM_CLOSE;
				cmd_d = '{cs_n: acc_cs_n, op: SRM_OP_PRE};
			end
			SRM_CLOSE, SRM_MODE: begin
				state_d = SRM_IDLE;
			end
			SRM_RF_PRE: begin
				state_d = SRM_RF_REF;
				cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_REF};
			end
			SRM_RF_REF: begin
				// extras follow only while no access waits
				if (refresh_enable_bit & (rpend_q > 4'h1) & ~acc_req_i & ~hold_req) begin
					cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_REF};
				end else begin
					state_d = SRM_IDLE;
				end
			end
			SRM_SR_PRE: begin
				// refresh in the same cycle as cke low
				state_d = SRM_SR_IN;
				cmd_d = '{cs_n: sd_cs_n, op: SRM_OP_REF};
				wait_d = 8'h00;
			end
			SRM_SR_IN: begin
				if (wait_q < min_active_time) begin
					wait_d = wait_q + 8'h01;
				end else if (exit_req_q | hold_req) begin
					state_d = SRM_SR_WAKE;
					wait_d = 8'h00;
				end
			end
			SRM_SR_WAKE: begin
				// sixteen ticks from cke high before any activate or acknowledge
				if (wait_q < `SRM_WAKE_CYCLES - 8'h01) begin
					wait_d = wait_q + 8'h01;
				end else begin
					state_d = hold_req ? SRM_HOLD : SRM_IDLE;
				end
			end
			SRM_HOLD: begin
				if (~hold_req) begin
					state_d = SRM_IDLE;
				end
			end
			default: begin
				state_d = SRM_IDLE;
			end
		endcase
	end

	// controller registers advance on memory clock edges
	// commands change only on a tick, so each stands one full memory clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SRM_IDLE;
			cmd_q <= '{cs_n: 4'hF, op: SRM_OP_NOP};
			la_q <= 17'h0_0000;
			wait_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= mtick & done_d;
			if (mtick) begin
				state_q <= state_d;
				cmd_q <= cmd_d;
				la_q <= la_d;
				wait_q <= wait_d;
			end
		end
	end

	// row bits above the precharge line and the flag, caught at activate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_q <= 5'h00;
			flag_q <= 1'b1;
		end else if (mtick & (state_q == SRM_IDLE) & (state_d == SRM_ACT)) begin
			upper_q <= row_addr[15:11];
			flag_q <= flag;
		end
	end

	// pin mapping: wide port from line 3, narrow port from line 1
	// the port choice is read live; software changes it only while idle
	assign external_address_bus_o = narrow ? {3'b000, la_q, 1'b0} : {1'b0, la_q, 3'b000};
	assign sdram_cmd_o = cmd_q;
	assign sdram_clock_enable_out_o = ~sr_q;
	assign hold_acknowledge_o = in_hold;
	assign acc_done_o = done_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

endmodule // srm_ctrl

// File: sim/srm_ctrl_props.sv
`timescale 1ns/100ps

module srm_ctrl_props import srm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic memory_clock_out_i,
	input wire logic hold_acknowledge_o,
	input wire srm_cmd_type sdram_cmd_o,
	input wire logic [20:0] external_address_bus_o,
	input wire logic sdram_clock_enable_out_o
);
	srm_op_type last_q; // last command other than idle
	logic mc_q; // memory clock one sample back
	logic cke_q; // clock enable one sample back
	logic [4:0] wake_q; // memory clocks since clock enable rose, saturating
	wire srm_op_type op = sdram_cmd_o.op;
	wire logic cke = sdram_clock_enable_out_o;
	wire logic [20:0] ea = external_address_bus_o;

	// history for the properties; saturated wake count so reset needs no wake-up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_q <= SRM_OP_NOP;
			mc_q <= 1'b0;
			cke_q <= 1'b1;
			wake_q <= 5'h1F;
		end else begin
			mc_q <= memory_clock_out_i;
			cke_q <= cke;
			if (op != SRM_OP_NOP)
				last_q <= op;
			if (cke && !cke_q)
				wake_q <= 5'h00;
			else if (memory_clock_out_i && !mc_q && wake_q != 5'h1F)
				wake_q <= wake_q + 5'h01;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	AST_COL_NOPRE: assert property (
		op inside {SRM_OP_READ, SRM_OP_WRITE} |-> !(ea[13] && ea[11]))
		else $error("precharge line high during a column command");
	AST_REF_PRE: assert property (
		$changed(sdram_cmd_o) && op == SRM_OP_REF |-> last_q inside {SRM_OP_PRE, SRM_OP_REF})
		else $error("refresh without a close of all banks before it");
	AST_CKE_REF: assert property (
		$fell(cke) |-> op == SRM_OP_REF)
		else $error("clock enable fell without a refresh command");
	AST_WAKE_ACT: assert property (
		$changed(sdram_cmd_o) && op == SRM_OP_ACT |-> wake_q >= 5'h10)
		else $error("activate too soon after clock enable rose");
	AST_WAKE_HOLD: assert property (
		$rose(hold_acknowledge_o) |-> cke && wake_q >= 5'h10)
		else $error("hold acknowledged before the memory woke up");
	AST_SR_NOACT: assert property (
		!cke |-> op != SRM_OP_ACT)
		else $error("activate while the memory sleeps");
	AST_MODE_VAL: assert property (
		op == SRM_OP_MRS |-> ea inside {21'h0110, 21'h0190, 21'h0044, 21'h0064})
		else $error("wrong mode value on the address pins");
	AST_REF_CS: assert property (
		op == SRM_OP_REF |-> sdram_cmd_o.cs_n != 4'hF)
		else $error("refresh selects no space");
endmodule // srm_ctrl_props

// File: sim/srm_sdram_model.sv
`timescale 1ns/100ps

module srm_sdram_model import srm_pkg::*; (
	output logic mclk_o,
	input wire srm_cmd_type cmd_i,
	input wire logic [20:0] addr_i,
	input wire logic cke_i,
	output logic [20:0] act_a_o,
	output logic [20:0] col_a_o,
	output logic [20:0] mode_a_o,
	output logic [3:0] ref_cs_o,
	output logic [7:0] ref_n_o,
	output logic [7:0] col_n_o,
	output logic [7:0] mrs_n_o
);
	// counters start clear; clock starts low
	initial begin
		mclk_o = 1'b0;
		ref_n_o = 8'h00;
		col_n_o = 8'h00;
		mrs_n_o = 8'h00;
	end

	// memory clock runs free, so it is up again before any exit
	always #40 mclk_o = ~mclk_o;

	// devices take the command lines on the memory clock; deaf while asleep
	always @(posedge mclk_o) begin
		if (cke_i) begin
			case (cmd_i.op)
				SRM_OP_ACT: act_a_o <= addr_i;
				SRM_OP_READ, SRM_OP_WRITE: begin
					col_a_o <= addr_i;
					col_n_o <= col_n_o + 8'h01;
				end
				SRM_OP_REF: begin
					ref_cs_o <= cmd_i.cs_n;
					ref_n_o <= ref_n_o + 8'h01;
				end
				SRM_OP_MRS: begin
					mode_a_o <= addr_i;
					mrs_n_o <= mrs_n_o + 8'h01;
				end
				default: ;
			endcase
		end
	end
endmodule // srm_sdram_model

// File: sim/srm_ctrl_bench.sv
`timescale 1ns/100ps

module srm_ctrl_bench import srm_pkg::*; ;
	logic clk_i = 1'b0; // system clock
	logic rst_i = 1'b1; // synchronous reset
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, acc_req = 1'b0, hold = 1'b0;
	logic [31:0] adr = '0, dat = '0, rdat, wb_dat;
	srm_access_type acc = '0; // access request bundle
	srm_cmd_type cmd; // sdram command pins
	logic wb_ack, done, hack, cke, mclk;
	logic [20:0] ea, m_act, m_col, m_mode;
	logic [3:0] m_cs;
	logic [7:0] m_ref, m_coln, m_mrs;
	int mismatches = 0, n_checks = 0;

	// 125 MHz system clock
	always #4 clk_i = ~clk_i;

	srm_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat),
		.wb_ack_o(wb_ack), .acc_req_i(acc_req), .acc_i(acc), .acc_done_o(done),
		.memory_clock_out_i(mclk), .hold_req_i(hold), .hold_acknowledge_o(hack),
		.sdram_cmd_o(cmd), .external_address_bus_o(ea), .sdram_clock_enable_out_o(cke));
	srm_sdram_model u_mem (.mclk_o(mclk), .cmd_i(cmd), .addr_i(ea), .cke_i(cke),
		.act_a_o(m_act), .col_a_o(m_col), .mode_a_o(m_mode), .ref_cs_o(m_cs),
		.ref_n_o(m_ref), .col_n_o(m_coln), .mrs_n_o(m_mrs));

	// logical address lines onto pins: wide from pin 3, narrow from pin 1
	function automatic logic [20:0] lay(input logic [19:0] l, input logic n);
		return n ? {l, 1'b0} : {l[17:0], 3'h0};
	endfunction

	// one counted compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask

	// a wait that ran out of time counts as a mismatch
	task automatic waited(input logic ok);
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, ok, 1'b1);
		end
	endtask

	// single wishbone cycle; read data taken at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {24'h00_0000, a};
		dat <= d;
		@(posedge clk_i);
		for (n = 0; n < 50 && wb_ack !== 1'b1; n++)
			@(posedge clk_i);
		waited(wb_ack === 1'b1);
		rdat = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// one access held until done, then wait for the memory to take the column
	task automatic access(input logic [31:0] a, input logic p);
		int n;
		logic [7:0] c0;
		c0 = m_coln;
		acc_req <= 1'b1;
		acc <= '{a, 2'h0, ~p, p};
		for (n = 0; n < 400 && done !== 1'b1; n++)
			@(posedge clk_i);
		waited(done === 1'b1);
		acc_req <= 1'b0;
		for (n = 0; n < 30 && m_coln == c0; n++)
			@(posedge clk_i);
		waited(m_coln != c0);
	endtask

	// reset values, an unmapped read, memory type write
	task automatic t_regs();
		logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
		logic [31:0] rv [5] = '{32'h0, 32'h0000_05DC, 32'h0000_0071, 32'h0, 32'h0};
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, ra[i], '0);
			chk(rdat, rv[i]);
		end
		wb(1'b1, 8'h0C, 32'h0000_0005);
		wb(1'b0, 8'h0C, '0);
		chk(rdat, 32'h0000_0005);
		$display("test regs done");
	endtask

	// mode set for both latencies on both ports
	task automatic t_mode();
		int n;
		logic [7:0] c0;
		for (int i = 0; i < 4; i++) begin
			c0 = m_mrs;
			wb(1'b1, 8'h08, 32'h0000_0070 | 32'(i & 1));
			wb(1'b1, 8'h00, 32'h0000_0004 | 32'((i >> 1) << 3));
			for (n = 0; n < 100 && m_mrs == c0; n++)
				@(posedge clk_i);
			chk(32'(m_mode), 32'(lay(20'h0_0022 | 20'((i & 1) << 4), i[1])));
		end
		$display("test mode done");
	endtask

	// row and column phases for every column count and width
	task automatic t_map();
		logic [31:0] a, r;
		logic [19:0] lr, lc;
		int nc;
		a = 32'h0ABC_DEF5;
		for (int n = 0; n < 2; n++) begin
			for (int w = 0; w < 4 - 2 * n; w++) begin
				for (int c = 0; c < 3; c++) begin
					nc = 8 + c;
					wb(1'b1, 8'h00, 32'((c << 6) | (w << 4) | (n << 3)));
					access(a, c[0]);
					r = a >> (nc + w);
					lr = {3'h0, ~c[0], r[15:0]};
					lc = {4'h0, lr[15:11], 11'h000} | 20'((a >> w) & ((32'h1 << nc) - 1));
					chk(32'(m_act), 32'(lay(lr, n[0])));
					chk(32'(m_col & ~lay(20'h1_0000, n[0])), 32'(lay(lc, n[0])));
				end
			end
		end
		$display("test map done");
	endtask

	// no refresh while disabled, then one expiry with clamped extras
	task automatic t_ref();
		int n;
		logic [7:0] b;
		wb(1'b1, 8'h04, 32'h0000_70C8);
		b = m_ref;
		repeat (2500) @(posedge clk_i);
		chk(32'(m_ref), 32'(b));
		wb(1'b1, 8'h00, 32'h0000_0001);
		for (n = 0; n < 3000 && m_ref == b; n++)
			@(posedge clk_i);
		repeat (400) @(posedge clk_i);
		chk(32'(m_ref - b), 32'h0000_0005);
		chk(32'(m_cs), 32'h0000_000A);
		wb(1'b1, 8'h00, '0);
		$display("test refresh done");
	endtask

	// self-refresh entry, exit, wake-up and hold
	task automatic t_self();
		int n;
		time tf;
		wb(1'b1, 8'h00, 32'h0000_0002); // refresh enable cleared in the same write
		for (n = 0; n < 200 && cke !== 1'b0; n++)
			@(posedge clk_i);
		tf = $time;
		wb(1'b0, 8'h00, '0);
		chk(32'({rdat[1], cke}), 32'h0000_0002);
		wb(1'b1, 8'h00, '0); // leave, then read back at once
		wb(1'b0, 8'h00, '0);
		for (n = 0; n < 400 && cke !== 1'b1; n++)
			@(posedge clk_i);
		chk(32'($time - tf >= 552), 32'h0000_0001);
		access(32'h0000_1234, 1'b0);
		chk(32'(m_act), 32'(lay(20'h1_0012, 1'b0)));
		wb(1'b1, 8'h00, 32'h0000_0002);
		for (n = 0; n < 200 && cke !== 1'b0; n++)
			@(posedge clk_i);
		hold <= 1'b1;
		for (n = 0; n < 800 && hack !== 1'b1; n++)
			@(posedge clk_i);
		chk(32'({hack, cke}), 32'h0000_0003);
		wb(1'b1, 8'h00, 32'h0000_0002);
		wb(1'b0, 8'h00, '0);
		chk(32'({rdat[1], cke}), 32'h0000_0001);
		hold <= 1'b0;
		for (n = 0; n < 50 && hack !== 1'b0; n++)
			@(posedge clk_i);
		chk(32'(hack), 32'h0);
		$display("test self-refresh done");
	endtask

	// counts, verdict, end of run
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_regs();
		t_mode();
		t_map();
		t_ref();
		t_self();
		results();
	end

	// watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge clk_i);
		mismatches++;
		results();
	end
endmodule // srm_ctrl_bench

bind srm_ctrl srm_ctrl_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.memory_clock_out_i, .hold_acknowledge_o, .sdram_cmd_o, .external_address_bus_o,
	.sdram_clock_enable_out_o);
